// ===== core/ccb_consts.vh
`ifndef CCB_CONSTS_VH
`define CCB_CONSTS_VH
// data-side operation codes, and the code used for instruction fetch
`define CCB_OP_LOAD 3'h0
`define CCB_OP_LOADM 3'h1
`define CCB_OP_STOREM 3'h2
`define CCB_OP_SWAP 3'h3
`define CCB_OP_EVICT 3'h4
`define CCB_OP_FETCH 3'h5
// transfer type codes
`define CCB_TRAN_ADDR 2'h0
`define CCB_TRAN_NSEQ 2'h2
`define CCB_TRAN_SEQ 2'h3
// burst indication codes
`define CCB_BURST_NONE 2'h0
`define CCB_BURST_FOUR 2'h2
// protection bit: opcode fetch or data
`define CCB_PROT_FETCH 1'h0
`define CCB_PROT_DATA 1'h1
// line geometry
`define CCB_LINE_WORDS 5'h04
`define CCB_MAX_WORDS 5'h10
// register byte offsets
`define CCB_REG_CTRL 4'h0
`define CCB_REG_STATUS 4'h4
`define CCB_REG_ABORT_ADDR 4'h8
// field positions
`define CCB_CTRL_TEST 0
`define CCB_CTRL_ABORT_EN 1
`define CCB_STAT_BUSY 0
`define CCB_STAT_ABORT 1
`define CCB_STAT_TEST 2
// reset values
`define CCB_CTRL_RESET 2'h2
`endif

// ===== core/ccb_word_mem.v
`timescale 1ns/1ps
// small word store, registered read data
module ccb_word_mem #(
   parameter DW = 32,
   parameter AW = 4
) (
   // clock
   input wire sys_clk,
   // write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   // read port
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data_r
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_r <= mem[rd_addr];
   end
endmodule

// ===== core/ccb_bus_master.v
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "ccb_consts.vh"
module ccb_bus_master (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // avalon register slave
   input wire [3:0] av_address,
   input wire av_read,
   input wire av_write,
   input wire [31:0] av_writedata,
   output reg [31:0] av_readdata_r,
   output reg av_waitrequest_r,
   // data-side request from core and caches
   input wire d_req,
   input wire [2:0] d_op,
   input wire [31:0] d_addr,
   input wire [4:0] d_count,
   input wire d_cached,
   input wire d_bufferable,
   input wire d_writeback,
   input wire d_dirty,
   input wire wbuf_empty,
   input wire wd_we,
   input wire [3:0] wd_idx,
   input wire [31:0] wd_data,
   output reg d_done_r,
   // instruction-side request
   input wire i_req,
   input wire [31:0] i_addr,
   output reg i_done_r,
   // words returned to core and cache
   input wire core_seq,
   output reg core_valid_r,
   output reg [31:0] core_data_r,
   output reg fill_we_r,
   output reg [1:0] fill_idx_r,
   output reg [31:0] fill_data_r,
   output reg abort_r,
   // system bus master side
   output reg bus_req_r,
   input wire bus_gnt,
   output reg [1:0] btran_r,
   output reg [31:0] baddr_r,
   output reg bwrite_r,
   output reg [31:0] bwdata_r,
   output reg [1:0] burst_r,
   output reg blok_r,
   output reg bprot_r,
   input wire [31:0] brdata,
   input wire bdone,
   input wire berror,
   // system bus slave side
   input wire dsel,
   input wire bwrite_in,
   output reg sl_done_r,
   output reg [31:0] sl_rdata_r
);
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_PREP = 4'h2;
   localparam [3:0] S_ARB = 4'h4;
   localparam [3:0] S_XFER = 4'h8;

   reg [3:0] state_r;
   reg [2:0] op_r;
   reg [31:0] addr_r;
   reg [4:0] left_r;
   reg [3:0] idx_r;
   reg is_wr_r;
   reg burst4_r;
   reg first_r;
   reg lfill_r;
   reg bufd_r;
   reg lock_r;
   reg swap_r;
   reg fetch_r;
   reg [1:0] want_r;
   reg got_want_r;
   reg stream_r;
   reg test_r;
   reg abort_en_r;
   reg abort_seen_r;
   reg [31:0] abort_addr_r;

   wire [31:0] mem_rdata;
   wire [31:0] addr_inc;
   wire last_word;
   wire av_take;
   wire ignore_err;
   wire at_want;
   wire [31:0] status_word;

   assign addr_inc = addr_r + 32'h0000_0004;
   assign last_word = (left_r == 5'h01);
   assign av_take = (av_read | av_write) & ~av_waitrequest_r;
   assign ignore_err = lfill_r | (is_wr_r & bufd_r);
   assign at_want = (addr_r[3:2] == want_r);
   assign status_word = {24'h0, state_r, 1'b0, test_r, abort_seen_r,
                         ~state_r[0]};

   ccb_word_mem #(
      .DW(32),
      .AW(4)
   ) u_mem (
      .sys_clk(sys_clk),
      .wr_en(wd_we),
      .wr_addr(wd_idx),
      .wr_data(wd_data),
      .rd_addr(idx_r),
      .rd_data_r(mem_rdata)
   );

   // register slave: one wait cycle, then completes
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         av_waitrequest_r <= 1'b1;
         av_readdata_r <= 32'h0;
         test_r <= 1'b0;
         abort_en_r <= 1'b1;
      end
      else
      begin
         if ((av_read | av_write) & av_waitrequest_r)
         begin
            av_waitrequest_r <= 1'b0;
         end
         else
         begin
            av_waitrequest_r <= 1'b1;
         end
         if (av_read & av_waitrequest_r)
         begin
            case (av_address)
               `CCB_REG_CTRL: av_readdata_r <= {30'h0, abort_en_r, test_r};
               `CCB_REG_STATUS: av_readdata_r <= status_word;
               `CCB_REG_ABORT_ADDR: av_readdata_r <= abort_addr_r;
               default: av_readdata_r <= 32'h0;
            endcase
         end
         if (av_take & av_write & (av_address == `CCB_REG_CTRL))
         begin
            test_r <= av_writedata[`CCB_CTRL_TEST];
            abort_en_r <= av_writedata[`CCB_CTRL_ABORT_EN];
         end
      end
   end

   // slave answer while in test mode
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sl_done_r <= 1'b0;
         sl_rdata_r <= 32'h0;
      end
      else
      begin
         sl_done_r <= test_r & dsel & ~sl_done_r;
         if (test_r & dsel & ~bwrite_in)
         begin
            sl_rdata_r <= status_word;
         end
      end
   end

   // transfer engine
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_r <= S_IDLE;
         op_r <= `CCB_OP_LOAD;
         addr_r <= 32'h0;
         left_r <= 5'h0;
         idx_r <= 4'h0;
         is_wr_r <= 1'b0;
         burst4_r <= 1'b0;
         first_r <= 1'b0;
         lfill_r <= 1'b0;
         bufd_r <= 1'b0;
         lock_r <= 1'b0;
         swap_r <= 1'b0;
         fetch_r <= 1'b0;
         want_r <= 2'h0;
         got_want_r <= 1'b0;
         stream_r <= 1'b0;
         d_done_r <= 1'b0;
         i_done_r <= 1'b0;
         core_valid_r <= 1'b0;
         core_data_r <= 32'h0;
         fill_we_r <= 1'b0;
         fill_idx_r <= 2'h0;
         fill_data_r <= 32'h0;
         abort_r <= 1'b0;
         abort_seen_r <= 1'b0;
         abort_addr_r <= 32'h0;
         bus_req_r <= 1'b0;
         btran_r <= `CCB_TRAN_ADDR;
         baddr_r <= 32'h0;
         bwrite_r <= 1'b0;
         bwdata_r <= 32'h0;
         burst_r <= `CCB_BURST_NONE;
         blok_r <= 1'b0;
         bprot_r <= `CCB_PROT_DATA;
      end
      else
      begin
         d_done_r <= 1'b0;
         i_done_r <= 1'b0;
         core_valid_r <= 1'b0;
         fill_we_r <= 1'b0;
         abort_r <= 1'b0;
         if (av_take & av_write & (av_address == `CCB_REG_STATUS) &
             av_writedata[`CCB_STAT_ABORT])
         begin
            abort_seen_r <= 1'b0;
         end
         case (state_r)
            S_IDLE:
            begin
               btran_r <= `CCB_TRAN_ADDR;
               first_r <= 1'b1;
               idx_r <= 4'h0;
               got_want_r <= 1'b0;
               stream_r <= 1'b0;
               swap_r <= 1'b0;
               if (test_r)
               begin
                  bus_req_r <= 1'b0;
               end
               else if (d_req & ~d_done_r &
                        ((d_op != `CCB_OP_SWAP) | wbuf_empty))
               begin
                  // data side served ahead of fetch
                  op_r <= d_op;
                  fetch_r <= 1'b0;
                  bprot_r <= `CCB_PROT_DATA;
                  want_r <= d_addr[3:2];
                  lfill_r <= 1'b0;
                  burst4_r <= 1'b0;
                  lock_r <= 1'b0;
                  bufd_r <= d_bufferable;
                  addr_r <= {d_addr[31:2], 2'h0};
                  left_r <= (d_count > `CCB_MAX_WORDS) ? `CCB_MAX_WORDS :
                            d_count;
                  is_wr_r <= (d_op == `CCB_OP_STOREM);
                  state_r <= S_PREP;
                  bus_req_r <= 1'b1;
                  if (d_cached & ((d_op == `CCB_OP_LOAD) |
                                  (d_op == `CCB_OP_LOADM)))
                  begin
                     lfill_r <= 1'b1;
                     burst4_r <= 1'b1;
                     addr_r <= {d_addr[31:4], 4'h0};
                     left_r <= `CCB_LINE_WORDS;
                  end
                  else if (d_op == `CCB_OP_SWAP)
                  begin
                     left_r <= 5'h01;
                     swap_r <= 1'b1;
                     bufd_r <= 1'b0;
                     lock_r <= ~d_cached;
                  end
                  else if (d_op == `CCB_OP_EVICT)
                  begin
                     addr_r <= {d_addr[31:4], 4'h0};
                     left_r <= `CCB_LINE_WORDS;
                     burst4_r <= 1'b1;
                     is_wr_r <= 1'b1;
                     bufd_r <= 1'b1;
                     if (~(d_writeback & d_dirty))
                     begin
                        // clean or write-through line: drop it
                        state_r <= S_IDLE;
                        bus_req_r <= 1'b0;
                        d_done_r <= 1'b1;
                     end
                  end
               end
               else if (i_req & ~i_done_r)
               begin
                  op_r <= `CCB_OP_FETCH;
                  fetch_r <= 1'b1;
                  bprot_r <= `CCB_PROT_FETCH;
                  want_r <= i_addr[3:2];
                  lfill_r <= 1'b1;
                  burst4_r <= 1'b1;
                  lock_r <= 1'b0;
                  bufd_r <= 1'b0;
                  is_wr_r <= 1'b0;
                  addr_r <= {i_addr[31:4], 4'h0};
                  left_r <= `CCB_LINE_WORDS;
                  state_r <= S_PREP;
                  bus_req_r <= 1'b1;
               end
            end
            S_PREP:
            begin
               btran_r <= `CCB_TRAN_ADDR;
               state_r <= S_ARB;
            end
            S_ARB:
            begin
               if (bus_gnt)
               begin
                  btran_r <= first_r ? `CCB_TRAN_NSEQ :
                             `CCB_TRAN_SEQ;
                  baddr_r <= addr_r;
                  bwrite_r <= is_wr_r;
                  bwdata_r <= mem_rdata;
                  burst_r <= burst4_r ? `CCB_BURST_FOUR :
                             `CCB_BURST_NONE;
                  blok_r <= lock_r;
                  state_r <= S_XFER;
               end
            end
            S_XFER:
            begin
               if (bdone | berror)
               begin
                  btran_r <= `CCB_TRAN_ADDR;
                  if (~is_wr_r & lfill_r)
                  begin
                     fill_we_r <= 1'b1;
                     fill_idx_r <= addr_r[3:2];
                     fill_data_r <= brdata;
                     if (at_want | (got_want_r & stream_r & core_seq))
                     begin
                        core_valid_r <= 1'b1;
                        core_data_r <= brdata;
                        got_want_r <= 1'b1;
                        stream_r <= 1'b1;
                     end
                     else if (got_want_r)
                     begin
                        stream_r <= 1'b0;
                     end
                  end
                  else if (~is_wr_r)
                  begin
                     core_valid_r <= 1'b1;
                     core_data_r <= brdata;
                  end
                  if (berror & ~ignore_err)
                  begin
                     abort_r <= abort_en_r;
                     abort_seen_r <= 1'b1;
                     abort_addr_r <= addr_r;
                     state_r <= S_IDLE;
                     bus_req_r <= 1'b0;
                     blok_r <= 1'b0;
                     d_done_r <= ~fetch_r;
                     i_done_r <= fetch_r;
                  end
                  else if (swap_r & ~is_wr_r)
                  begin
                     // write half of the swap, still locked if the swap is uncached
                     is_wr_r <= 1'b1;
                     first_r <= 1'b1;
                     state_r <= S_PREP;
                  end
                  else if (last_word)
                  begin
                     state_r <= S_IDLE;
                     bus_req_r <= 1'b0;
                     blok_r <= 1'b0;
                     burst_r <= `CCB_BURST_NONE;
                     d_done_r <= ~fetch_r;
                     i_done_r <= fetch_r;
                  end
                  else
                  begin
                     left_r <= left_r - 5'h01;
                     idx_r <= idx_r + 4'h1;
                     addr_r <= addr_inc;
                     // new 4KB region restarts nonsequential
                     first_r <= (addr_inc[11:0] == 12'h000);
                     state_r <= S_PREP;
                  end
               end
            end
            default:
            begin
               state_r <= S_IDLE;
            end
         endcase
         if (bus_req_r & ~bus_gnt & (state_r == S_XFER))
         begin
            // grant lost: re-arbitrate same transfer
            btran_r <= `CCB_TRAN_ADDR;
            state_r <= S_ARB;
         end
      end
   end
endmodule

// ===== verification/ccb_bus_master_assertions.sv
`timescale 1ns/1ps
module ccb_bus_master_chk (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // master bus
   input wire [1:0] btran_r,
   input wire [31:0] baddr_r,
   input wire [1:0] burst_r,
   input wire blok_r,
   input wire bus_gnt,
   input wire abort_r,
   // core and cache
   input wire core_valid_r,
   input wire [31:0] core_data_r,
   input wire fill_we_r,
   input wire [31:0] fill_data_r,
   // slave side
   input wire dsel,
   input wire sl_done_r
);
   reg [31:0] last_r;
   wire xfer = btran_r != 2'h0;
   // address of the previous transfer
   always @(posedge sys_clk)
   begin
      if (rst)
         last_r <= 32'h0;
      else if (xfer)
         last_r <= baddr_r;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_BURST_CODE: assert property (burst_r == 2'h0 || burst_r == 2'h2)
      else $error("burst code reserved");
   AST_TRAN_CODE: assert property (btran_r != 2'h1)
      else $error("transfer type reserved");
   AST_WORD_ALIGN: assert property (xfer |-> baddr_r[1:0] == 2'h0)
      else $error("address not word aligned");
   AST_SEQ_STEP: assert property (btran_r == 2'h3 && $past(btran_r) == 2'h0
      |-> baddr_r == last_r + 32'h4) else $error("sequential step wrong");
   AST_NO_SEQ_4K: assert property (btran_r == 2'h3
      |-> baddr_r[11:0] != 12'h0) else $error("sequential at 4KB");
   AST_LINE_FIRST: assert property (btran_r == 2'h2 && burst_r == 2'h2
      |-> baddr_r[3:0] == 4'h0) else $error("burst not line aligned");
   AST_LOCK_SINGLE: assert property (xfer && blok_r
      |-> btran_r == 2'h2 && burst_r == 2'h0) else $error("locked not single");
   AST_STREAM: assert property (fill_we_r && core_valid_r
      |-> fill_data_r == core_data_r) else $error("core and cache differ");
   AST_GNT_FIRST: assert property (xfer && $past(btran_r) == 2'h0
      |-> $past(bus_gnt)) else $error("transfer without grant");
   AST_SLAVE_ANS: assert property (sl_done_r |-> $past(dsel))
      else $error("slave answer without select");
   AST_NO_FILL_ABORT: assert property (abort_r |-> burst_r == 2'h0)
      else $error("abort on burst transfer");
   cover property (xfer && burst_r == 2'h2);
   cover property (xfer && blok_r);
   cover property (sl_done_r);
endmodule
bind ccb_bus_master ccb_bus_master_chk ccb_bus_master_chk_inst (
   .sys_clk(sys_clk), .rst(rst), .btran_r(btran_r), .baddr_r(baddr_r),
   .burst_r(burst_r), .blok_r(blok_r), .bus_gnt(bus_gnt), .abort_r(abort_r),
   .core_valid_r(core_valid_r), .core_data_r(core_data_r),
   .fill_we_r(fill_we_r), .fill_data_r(fill_data_r), .dsel(dsel),
   .sl_done_r(sl_done_r));

// ===== verification/ccb_bus_partner.sv
`timescale 1ns/1ps
module ccb_bus_partner (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // bench controls
   input wire test_mode,
   input wire err_en,
   input wire [3:0] slow,
   // master side
   input wire bus_req_r,
   input wire [1:0] btran_r,
   input wire [31:0] baddr_r,
   // slave answer
   output logic bus_gnt,
   output logic [31:0] brdata,
   output logic bdone,
   output logic berror
);
   logic [3:0] cnt;
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         bus_gnt <= 1'b0;
         bdone <= 1'b0;
         berror <= 1'b0;
         cnt <= 4'h0;
         brdata <= 32'h0;
      end
      else
      begin
         // bus stays with this master while it asks; none in test mode
         bus_gnt <= bus_req_r && !test_mode;
         bdone <= 1'b0;
         berror <= 1'b0;
         cnt <= cnt + 4'h1;
         if (btran_r == 2'h0 || bdone || berror)
            cnt <= 4'h0;
         else if (cnt == slow)
         begin
            bdone <= !err_en;
            berror <= err_en;
            brdata <= baddr_r;
         end
         // released data lines do not keep the last word
         if (bdone || berror)
            brdata <= ~brdata;
      end
   end
endmodule

// ===== verification/ccb_bus_master_bench.sv
`timescale 1ns/1ps
`include "ccb_consts.vh"
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
      end \
   end
module ccb_bus_master_bench;
   logic sys_clk, rst, av_read, av_write, d_req, d_cached, d_bufferable;
   logic d_writeback, d_dirty, wbuf_empty, i_req, core_seq, dsel;
   logic test_mode, err_en, bus_gnt, bdone, berror;
   logic [3:0] av_address, slow, f;
   logic [31:0] av_writedata, d_addr, i_addr, brdata, rd, cd0;
   logic [2:0] d_op;
   logic [4:0] d_count;
   logic [31:0] av_readdata_r, core_data_r, fill_data_r, baddr_r, bwdata_r;
   logic [31:0] sl_rdata_r;
   logic av_waitrequest_r, d_done_r, i_done_r, core_valid_r, fill_we_r;
   logic abort_r, bus_req_r, bwrite_r, blok_r, bprot_r, sl_done_r;
   logic [1:0] fill_idx_r, btran_r, burst_r;
   logic wd_we;
   logic [3:0] wd_idx;
   logic [31:0] wd_data;
   logic [31:0] ld [0:15];
   logic [31:0] la [0:15];
   logic [1:0] lt [0:15];
   logic [1:0] lb [0:15];
   logic lk [0:15];
   logic lw [0:15];
   logic lp [0:15];
   integer ln, ncore, nab, nsl, error_cnt, n_compared, i;
   ccb_bus_master ccb_bus_master_inst (.sys_clk(sys_clk), .rst(rst),
      .av_address(av_address), .av_read(av_read), .av_write(av_write),
      .av_writedata(av_writedata), .av_readdata_r(av_readdata_r),
      .av_waitrequest_r(av_waitrequest_r), .d_req(d_req), .d_op(d_op),
      .d_addr(d_addr), .d_count(d_count), .d_cached(d_cached),
      .d_bufferable(d_bufferable), .d_writeback(d_writeback),
      .d_dirty(d_dirty), .wbuf_empty(wbuf_empty), .wd_we(wd_we),
      .wd_idx(wd_idx), .wd_data(wd_data), .d_done_r(d_done_r), .i_req(i_req),
      .i_addr(i_addr), .i_done_r(i_done_r), .core_seq(core_seq),
      .core_valid_r(core_valid_r), .core_data_r(core_data_r),
      .fill_we_r(fill_we_r), .fill_idx_r(fill_idx_r),
      .fill_data_r(fill_data_r), .abort_r(abort_r), .bus_req_r(bus_req_r),
      .bus_gnt(bus_gnt), .btran_r(btran_r), .baddr_r(baddr_r),
      .bwrite_r(bwrite_r), .bwdata_r(bwdata_r), .burst_r(burst_r),
      .blok_r(blok_r), .bprot_r(bprot_r), .brdata(brdata), .bdone(bdone),
      .berror(berror), .dsel(dsel), .bwrite_in(1'b0),
      .sl_done_r(sl_done_r), .sl_rdata_r(sl_rdata_r));
   ccb_bus_partner ccb_bus_partner_inst (.sys_clk(sys_clk), .rst(rst),
      .test_mode(test_mode), .err_en(err_en), .slow(slow),
      .bus_req_r(bus_req_r), .btran_r(btran_r), .baddr_r(baddr_r),
      .bus_gnt(bus_gnt), .brdata(brdata), .bdone(bdone), .berror(berror));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // log of answered transfers and words given to the core
   always @(posedge sys_clk)
   begin
      if (!rst && btran_r != 2'h0 && (bdone || berror) && ln < 16)
      begin
         la[ln] = baddr_r;
         lt[ln] = btran_r;
         lb[ln] = burst_r;
         lk[ln] = blok_r;
         lw[ln] = bwrite_r;
         lp[ln] = bprot_r;
         ld[ln] = bwdata_r;
         ln = ln + 1;
      end
      if (!rst && core_valid_r)
      begin
         if (ncore == 0)
            cd0 = core_data_r;
         ncore = ncore + 1;
      end
      if (!rst)
      begin
         nab = nab + abort_r;
         nsl = nsl + sl_done_r;
      end
   end
   task print_verdict;
      begin
         $display("compared %0d mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task wait_hi(input integer s);
      integer k;
      begin
         k = 0;
         while ((s == 0 ? d_done_r : i_done_r) !== 1'b1 && k < 500)
         begin
            @(posedge sys_clk);
            k++;
         end
         `CHK("wait", 1, k < 500)
         if (k >= 500)
            print_verdict;
      end
   endtask
   task av(input w, input [3:0] a, input [31:0] wd);
      integer k;
      begin
         av_address <= a;
         av_writedata <= wd;
         av_write <= w;
         av_read <= !w;
         k = 0;
         do
         begin
            @(posedge sys_clk);
            k++;
         end
         while (av_waitrequest_r !== 1'b0 && k < 50);
         `CHK("avwait", 1, k < 50)
         if (k >= 50)
            print_verdict;
         rd = av_readdata_r;
         av_read <= 1'b0;
         av_write <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task op(input [2:0] o, input [31:0] a, input [4:0] n, input [3:0] fl);
      begin
         ln = 0;
         ncore = 0;
         d_op <= o;
         d_addr <= a;
         d_count <= n;
         {d_cached, d_bufferable, d_writeback, d_dirty} <= fl;
         d_req <= 1'b1;
         wait_hi(0);
         d_req <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task chk_run(input [31:0] b, input integer n, input [1:0] bu, input wr);
      integer j;
      logic [31:0] e;
      begin
         `CHK("count", n, ln)
         for (j = 0; j < n; j++)
         begin
            e = b + 4 * j;
            `CHK("addr", e, la[j])
            `CHK("tran", (j == 0 || e[11:0] == 0) ? 2'h2 : 2'h3, lt[j])
            `CHK("burst", bu, lb[j])
            `CHK("dir", wr, lw[j])
            if (wr)
               `CHK("wdata", 32'hD0 + j, ld[j])
         end
      end
   endtask
   initial
   begin
      rst = 1'b1;
      {av_read, av_write, d_req, d_cached, d_bufferable, i_req, dsel} = 0;
      {d_writeback, d_dirty, test_mode, err_en} = 0;
      {av_address, slow, av_writedata, d_addr, i_addr, d_op, d_count} = 0;
      {wbuf_empty, core_seq} = 2'h3;
      {wd_we, wd_idx, wd_data} = 0;
      {ln, ncore, nab, nsl, error_cnt, n_compared} = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      // write-data store: word i holds D0 plus i
      for (i = 0; i < 16; i++)
      begin
         wd_we <= 1'b1;
         wd_idx <= i[3:0];
         wd_data <= 32'hD0 + i;
         @(posedge sys_clk);
      end
      wd_we <= 1'b0;
      av(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 32'h2, rd)
      av(1'b0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      op(`CCB_OP_LOAD, 32'h108, 5'h01, 4'h8);
      chk_run(32'h100, 4, 2'h2, 1'b0);
      `CHK("streamed", 2, ncore)
      `CHK("wanted", 32'h108, cd0)
      core_seq <= 1'b0;
      op(`CCB_OP_LOAD, 32'h104, 5'h01, 4'h8);
      `CHK("nostream", 1, ncore)
      core_seq <= 1'b1;
      slow <= 4'h3;
      op(`CCB_OP_LOADM, 32'h204, 5'h02, 4'h8);
      chk_run(32'h200, 4, 2'h2, 1'b0);
      slow <= 4'h0;
      op(`CCB_OP_STOREM, 32'hFF8, 5'h04, 4'h0);
      chk_run(32'hFF8, 4, 2'h0, 1'b1);
      op(`CCB_OP_STOREM, 32'h1FC0, 5'h10, 4'h0);
      chk_run(32'h1FC0, 16, 2'h0, 1'b1);
      $display("loads and stores done");
      op(`CCB_OP_EVICT, 32'h200, 5'h04, 4'hB);
      chk_run(32'h200, 4, 2'h2, 1'b1);
      op(`CCB_OP_EVICT, 32'h200, 5'h04, 4'hA);
      `CHK("clean", 0, ln)
      op(`CCB_OP_EVICT, 32'h200, 5'h04, 4'h9);
      `CHK("wthru", 0, ln)
      $display("evict done");
      for (i = 0; i < 3; i++)
      begin
         f = i * 4;
         wbuf_empty <= 1'b0;
         fork
            op(`CCB_OP_SWAP, 32'h600, 5'h01, f);
            begin
               repeat (20) @(posedge sys_clk);
               `CHK("held", 1'b0, bus_req_r)
               wbuf_empty <= 1'b1;
            end
         join
         `CHK("swap", 2, ln)
         `CHK("swdir", 2'h1, {lw[0], lw[1]})
         `CHK("swtran", 4'hA, {lt[0], lt[1]})
         `CHK("swdata", 32'hD0, ld[1])
         `CHK("lock", f[3] ? 2'h0 : 2'h3, {lk[0], lk[1]})
      end
      $display("swap done");
      err_en <= 1'b1;
      op(`CCB_OP_STOREM, 32'h700, 5'h02, 4'h0);
      `CHK("abort", 1, nab)
      `CHK("ended", 1, ln)
      av(1'b0, `CCB_REG_ABORT_ADDR, 32'h0);
      `CHK("abortaddr", 32'h700, rd)
      av(1'b0, `CCB_REG_STATUS, 32'h0);
      `CHK("abortseen", 32'h12, rd)
      av(1'b1, `CCB_REG_STATUS, 32'h2);
      av(1'b0, `CCB_REG_STATUS, 32'h0);
      `CHK("abortclr", 32'h10, rd)
      op(`CCB_OP_LOAD, 32'h700, 5'h01, 4'h8);
      `CHK("fillabort", 1, nab)
      err_en <= 1'b0;
      i_addr <= 32'h340;
      i_req <= 1'b1;
      op(`CCB_OP_LOAD, 32'h400, 5'h01, 4'h8);
      `CHK("datafirst", 1'b1, lp[0])
      wait_hi(1);
      i_req <= 1'b0;
      `CHK("fetch", 32'h340, la[4])
      `CHK("fetchprot", 1'b0, lp[4])
      $display("abort and order done");
      av(1'b1, 4'h0, 32'h3);
      test_mode <= 1'b1;
      ln = 0;
      d_addr <= 32'h800;
      d_op <= `CCB_OP_LOAD;
      d_req <= 1'b1;
      repeat (12) @(posedge sys_clk);
      `CHK("testreq", 1'b0, bus_req_r)
      dsel <= 1'b1;
      @(posedge sys_clk);
      dsel <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK("slave", 1, nsl)
      `CHK("slrdata", 32'h14, sl_rdata_r)
      av(1'b1, 4'h0, 32'h2);
      test_mode <= 1'b0;
      wait_hi(0);
      d_req <= 1'b0;
      @(posedge sys_clk);
      `CHK("resumed", 4, ln)
      $display("test mode done");
      print_verdict;
   end
endmodule
